/* File: hw/ibc_slave.sv */
// Two-wire bus target: bus conditions, byte transfer, acknowledge and data crossing
`timescale 1ns/1ps
`default_nettype none
module ibc_slave #(
  parameter logic [6:0] DEV_ADDR   = ibc_pkg::DEV_ADDR_DEFAULT,
  parameter int         FIFO_WIDTH = ibc_pkg::RX_ENTRY_W,
  parameter int         FIFO_DEPTH = ibc_pkg::RX_DEPTH_DEFAULT
) (
  // System clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Link sampling clock
  input  wire logic        i_link_clk,
  // Bus pins
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  // Received bytes
  output logic             o_rx_valid,
  output logic [7:0]       o_rx_data,
  output logic             o_rx_first,
  input  wire logic        i_rx_ready,
  // Word to transmit on reads
  input  wire logic        i_tx_valid,
  input  wire logic [15:0] i_tx_word,
  output logic             o_tx_ready,
  // Status
  output logic             o_bus_active
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam logic [PW-1:0] PTR_LAST  = PW'(FIFO_DEPTH - 1);
  localparam logic [PW-1:0] PTR_ZERO  = '0;
  localparam logic [PW-1:0] PTR_STEP  = PW'(1);
  localparam logic [CW-1:0] CNT_FULL  = CW'(FIFO_DEPTH);
  localparam logic [CW-1:0] CNT_ZERO  = '0;
  localparam logic [CW-1:0] CNT_STEP  = CW'(1);

  // ---------------- Link domain ----------------
  logic             rst_l_meta;
  logic             rst_l;
  logic             scl_m;
  logic             scl_s;
  logic             scl_q;
  logic             sda_m;
  logic             sda_s;
  logic             sda_q;
  logic             rx_ack_m;
  logic             rx_ack_s;
  logic             tx_req_m;
  logic             tx_req_s;
  // Handshake toggles and held word shared with the system domain
  logic             rx_ack;
  logic             tx_req;
  logic [15:0]      tx_word_hold;

  ibc_pkg::ibc_state_t state;
  ibc_pkg::ibc_state_t next_state;
  logic [3:0]       bit_cnt;
  logic [3:0]       next_bit_cnt;
  logic [7:0]       shift;
  logic [7:0]       next_shift;
  logic [7:0]       tx_sh;
  logic [7:0]       next_tx_sh;
  logic             rw;
  logic             next_rw;
  logic             hi_next;
  logic             next_hi_next;
  logic [15:0]      cur_word;
  logic [15:0]      next_cur_word;
  logic [15:0]      word_l;
  logic [15:0]      next_word_l;
  logic             tx_ack_l;
  logic             next_tx_ack_l;
  logic [7:0]       rx_hold;
  logic [7:0]       next_rx_hold;
  logic             rx_first;
  logic             next_rx_first;
  logic             first_pending;
  logic             next_first_pending;
  logic             rx_req;
  logic             next_rx_req;
  logic             next_sda_oe;
  logic             active_l;
  logic             next_active_l;

  logic             start_det;
  logic             stop_det;
  logic             rise_det;
  logic             fall_det;
  logic             rx_busy;
  logic [15:0]      load_word;
  logic [7:0]       load_byte;

  // Link reset: asserts at once, releases on the link clock
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_l_meta <= 1'b1;
      rst_l      <= 1'b1;
    end else begin
      rst_l_meta <= 1'b0;
      rst_l      <= rst_l_meta;
    end
  end

  // Pin and handshake synchronisers
  always_ff @(posedge i_link_clk or posedge rst_l) begin
    if (rst_l) begin
      scl_m    <= 1'b1;
      scl_s    <= 1'b1;
      scl_q    <= 1'b1;
      sda_m    <= 1'b1;
      sda_s    <= 1'b1;
      sda_q    <= 1'b1;
      rx_ack_m <= 1'b0;
      rx_ack_s <= 1'b0;
      tx_req_m <= 1'b0;
      tx_req_s <= 1'b0;
    end else begin
      scl_m    <= i_scl;
      scl_s    <= scl_m;
      scl_q    <= scl_s;
      sda_m    <= i_sda;
      sda_s    <= sda_m;
      sda_q    <= sda_s;
      rx_ack_m <= rx_ack;
      rx_ack_s <= rx_ack_m;
      tx_req_m <= tx_req;
      tx_req_s <= tx_req_m;
    end
  end

  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  assign rise_det  = scl_s & ~scl_q;
  assign fall_det  = ~scl_s & scl_q;
  assign rx_busy   = rx_req ^ rx_ack_s;
  // High byte comes from the freshest word, low byte from the word in flight
  assign load_word = hi_next ? word_l : cur_word;
  assign load_byte = hi_next ? word_l[15:8] : cur_word[7:0];

  always_comb begin
    next_state         = state;
    next_bit_cnt       = bit_cnt;
    next_shift         = shift;
    next_tx_sh         = tx_sh;
    next_rw            = rw;
    next_hi_next       = hi_next;
    next_cur_word      = cur_word;
    next_word_l        = word_l;
    next_tx_ack_l      = tx_ack_l;
    next_rx_hold       = rx_hold;
    next_rx_first      = rx_first;
    next_first_pending = first_pending;
    next_rx_req        = rx_req;
    next_sda_oe        = o_sda_oe;
    if (tx_req_s != tx_ack_l) begin
      next_word_l   = tx_word_hold;
      next_tx_ack_l = ~tx_ack_l;
    end
    if (stop_det) begin
      next_state   = ibc_pkg::IBC_IDLE;
      next_sda_oe  = 1'b0;
      next_hi_next = 1'b1;
    end else if (start_det) begin
      next_state   = ibc_pkg::IBC_ADDR;
      next_bit_cnt = ibc_pkg::BIT_CNT_RESET;
      next_sda_oe  = 1'b0;
      next_hi_next = 1'b1;
    end else begin
      unique case (state)
        ibc_pkg::IBC_IDLE: begin
          next_sda_oe = 1'b0;
        end
        ibc_pkg::IBC_ADDR: begin
          if (rise_det) begin
            next_shift   = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + ibc_pkg::BIT_CNT_STEP;
          end else if (fall_det && bit_cnt == ibc_pkg::BITS_PER_BYTE) begin
            if (shift[7:1] == DEV_ADDR) begin
              next_state         = ibc_pkg::IBC_ACK;
              next_sda_oe        = 1'b1;
              next_rw            = shift[0];
              next_first_pending = 1'b1;
            end else begin
              next_state = ibc_pkg::IBC_IDLE;
            end
          end
        end
        ibc_pkg::IBC_ACK: begin
          if (fall_det) begin
            next_bit_cnt = ibc_pkg::BIT_CNT_RESET;
            if (rw == ibc_pkg::RW_READ) begin
              next_state    = ibc_pkg::IBC_TX;
              next_cur_word = load_word;
              next_tx_sh    = load_byte;
              next_sda_oe   = ~load_byte[7];
              next_hi_next  = ~hi_next;
            end else begin
              next_state  = ibc_pkg::IBC_RX;
              next_sda_oe = 1'b0;
            end
          end
        end
        ibc_pkg::IBC_RX: begin
          if (rise_det) begin
            next_shift   = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + ibc_pkg::BIT_CNT_STEP;
          end else if (fall_det && bit_cnt == ibc_pkg::BITS_PER_BYTE) begin
            next_state = ibc_pkg::IBC_ACK;
            // A byte that cannot be handed over is refused
            if (!rx_busy) begin
              next_rx_hold       = shift;
              next_rx_first      = first_pending;
              next_first_pending = 1'b0;
              next_rx_req        = ~rx_req;
              next_sda_oe        = 1'b1;
            end
          end
        end
        ibc_pkg::IBC_TX: begin
          if (rise_det) begin
            next_bit_cnt = bit_cnt + ibc_pkg::BIT_CNT_STEP;
          end else if (fall_det) begin
            if (bit_cnt == ibc_pkg::BITS_PER_BYTE) begin
              next_state  = ibc_pkg::IBC_MACK;
              next_sda_oe = 1'b0;
            end else begin
              next_tx_sh  = {tx_sh[6:0], 1'b0};
              next_sda_oe = ~tx_sh[6];
            end
          end
        end
        ibc_pkg::IBC_MACK: begin
          if (rise_det) begin
            if (sda_s) begin
              next_state   = ibc_pkg::IBC_IDLE;
              next_hi_next = 1'b1;
            end else begin
              next_state = ibc_pkg::IBC_MACK_END;
            end
          end
        end
        ibc_pkg::IBC_MACK_END: begin
          if (fall_det) begin
            next_state    = ibc_pkg::IBC_TX;
            next_bit_cnt  = ibc_pkg::BIT_CNT_RESET;
            next_cur_word = load_word;
            next_tx_sh    = load_byte;
            next_sda_oe   = ~load_byte[7];
            next_hi_next  = ~hi_next;
          end
        end
        default: begin
          next_state  = ibc_pkg::IBC_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
    next_active_l = (next_state != ibc_pkg::IBC_IDLE);
  end

  always_ff @(posedge i_link_clk or posedge rst_l) begin
    if (rst_l) begin
      state         <= ibc_pkg::IBC_IDLE;
      bit_cnt       <= ibc_pkg::BIT_CNT_RESET;
      shift         <= ibc_pkg::BYTE_RESET;
      tx_sh         <= ibc_pkg::BYTE_RESET;
      rw            <= 1'b0;
      hi_next       <= 1'b1;
      cur_word      <= ibc_pkg::WORD_RESET;
      word_l        <= ibc_pkg::WORD_RESET;
      tx_ack_l      <= 1'b0;
      rx_hold       <= ibc_pkg::BYTE_RESET;
      rx_first      <= 1'b0;
      first_pending <= 1'b0;
      rx_req        <= 1'b0;
      o_sda_oe      <= 1'b0;
      o_sda_o       <= ibc_pkg::SDA_PULL_LEVEL;
      active_l      <= 1'b0;
    end else begin
      state         <= next_state;
      bit_cnt       <= next_bit_cnt;
      shift         <= next_shift;
      tx_sh         <= next_tx_sh;
      rw            <= next_rw;
      hi_next       <= next_hi_next;
      cur_word      <= next_cur_word;
      word_l        <= next_word_l;
      tx_ack_l      <= next_tx_ack_l;
      rx_hold       <= next_rx_hold;
      rx_first      <= next_rx_first;
      first_pending <= next_first_pending;
      rx_req        <= next_rx_req;
      o_sda_oe      <= next_sda_oe;
      o_sda_o       <= ibc_pkg::SDA_PULL_LEVEL;
      active_l      <= next_active_l;
    end
  end

  // ---------------- System domain ----------------
  logic                  rx_req_m;
  logic                  rx_req_s;
  logic                  tx_ack_m;
  logic                  tx_ack_s;
  logic                  act_m;
  logic                  act_s;
  logic                  next_rx_ack;
  logic                  next_tx_req;
  logic [15:0]           next_tx_word_hold;
  logic                  next_tx_ready;
  logic [FIFO_WIDTH-1:0] mem [FIFO_DEPTH];
  logic [FIFO_WIDTH-1:0] next_mem [FIFO_DEPTH];
  logic [PW-1:0]         wr_ptr;
  logic [PW-1:0]         next_wr_ptr;
  logic [PW-1:0]         rd_ptr;
  logic [PW-1:0]         next_rd_ptr;
  logic [CW-1:0]         count;
  logic [CW-1:0]         next_count;
  logic [FIFO_WIDTH-1:0] head;
  logic                  push;
  logic                  pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PTR_LAST) ? PTR_ZERO : p + PTR_STEP;
  endfunction

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_req_m <= 1'b0;
      rx_req_s <= 1'b0;
      tx_ack_m <= 1'b0;
      tx_ack_s <= 1'b0;
      act_m    <= 1'b0;
      act_s    <= 1'b0;
    end else begin
      rx_req_m <= rx_req;
      rx_req_s <= rx_req_m;
      tx_ack_m <= tx_ack_l;
      tx_ack_s <= tx_ack_m;
      act_m    <= active_l;
      act_s    <= act_m;
    end
  end

  always_comb begin
    push              = (rx_req_s != rx_ack) && (count != CNT_FULL);
    pop               = o_rx_valid && i_rx_ready;
    next_mem          = mem;
    next_wr_ptr       = wr_ptr;
    next_rd_ptr       = rd_ptr;
    next_count        = count;
    next_rx_ack       = rx_ack;
    next_tx_req       = tx_req;
    next_tx_word_hold = tx_word_hold;
    // Link data stays stable until the acknowledge toggle returns
    if (push) begin
      next_mem[wr_ptr] = FIFO_WIDTH'({rx_first, rx_hold});
      next_wr_ptr      = ptr_inc(wr_ptr);
      next_rx_ack      = rx_req_s;
    end
    if (pop) begin
      next_rd_ptr = ptr_inc(rd_ptr);
    end
    if (push && !pop) begin
      next_count = count + CNT_STEP;
    end else if (pop && !push) begin
      next_count = count - CNT_STEP;
    end
    head = next_mem[next_rd_ptr];
    if (o_tx_ready && i_tx_valid) begin
      next_tx_word_hold = i_tx_word;
      next_tx_req       = ~tx_req;
      next_tx_ready     = 1'b0;
    end else begin
      next_tx_ready = (tx_req == tx_ack_s);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem[i] <= '0;
      end
      wr_ptr         <= PTR_ZERO;
      rd_ptr         <= PTR_ZERO;
      count          <= CNT_ZERO;
      rx_ack         <= 1'b0;
      tx_req         <= 1'b0;
      tx_word_hold   <= ibc_pkg::WORD_RESET;
      o_tx_ready     <= 1'b0;
      o_rx_valid     <= 1'b0;
      o_rx_data      <= ibc_pkg::BYTE_RESET;
      o_rx_first     <= 1'b0;
      o_bus_active   <= 1'b0;
    end else begin
      mem            <= next_mem;
      wr_ptr         <= next_wr_ptr;
      rd_ptr         <= next_rd_ptr;
      count          <= next_count;
      rx_ack         <= next_rx_ack;
      tx_req         <= next_tx_req;
      tx_word_hold   <= next_tx_word_hold;
      o_tx_ready     <= next_tx_ready;
      o_rx_valid     <= (next_count != CNT_ZERO);
      o_rx_data      <= head[7:0];
      o_rx_first     <= head[ibc_pkg::RX_FIRST_BIT];
      o_bus_active   <= act_s;
    end
  end

  // ---------------- Assertions ----------------
  property p_idle_release;
    @(posedge i_link_clk) disable iff (rst_l)
    (state == ibc_pkg::IBC_IDLE && !start_det) |=> !o_sda_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("SDA driven on idle bus");

  property p_start_addr;
    @(posedge i_link_clk) disable iff (rst_l)
    (start_det && !stop_det) |=> (state == ibc_pkg::IBC_ADDR
      && bit_cnt == ibc_pkg::BIT_CNT_RESET && !o_sda_oe);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("START not taken");

  property p_stop_end;
    @(posedge i_link_clk) disable iff (rst_l)
    stop_det |=> (state == ibc_pkg::IBC_IDLE && !o_sda_oe);
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("STOP did not end transfer");

  property p_write_more;
    @(posedge i_link_clk) disable iff (rst_l)
    (state == ibc_pkg::IBC_ACK && fall_det && rw != ibc_pkg::RW_READ && !start_det && !stop_det)
      |=> (state == ibc_pkg::IBC_RX && bit_cnt == ibc_pkg::BIT_CNT_RESET);
  endproperty
  a_write_more: assert property (p_write_more) else $error("Write did not continue");

  property p_abandon_low;
    @(posedge i_link_clk) disable iff (rst_l)
    (start_det || stop_det) |=> hi_next;
  endproperty
  a_abandon_low: assert property (p_abandon_low) else $error("Low byte not abandoned");

  property p_addr_ack;
    @(posedge i_link_clk) disable iff (rst_l)
    (state == ibc_pkg::IBC_ADDR && fall_det && bit_cnt == ibc_pkg::BITS_PER_BYTE
      && shift[7:1] == DEV_ADDR
      && !start_det && !stop_det) |=> (o_sda_oe && state == ibc_pkg::IBC_ACK);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("Address not acknowledged");

  property p_sda_change_low;
    @(posedge i_link_clk) disable iff (rst_l)
    $changed(o_sda_oe) |-> ($past(fall_det) || $past(start_det) || $past(stop_det)
      || $past(state) == ibc_pkg::IBC_IDLE);
  endproperty
  a_sda_change_low: assert property (p_sda_change_low) else $error("SDA moved with SCL high");

  property p_nack_release;
    @(posedge i_link_clk) disable iff (rst_l)
    (state == ibc_pkg::IBC_MACK && rise_det && sda_s && !start_det && !stop_det)
      |=> (state == ibc_pkg::IBC_IDLE && !o_sda_oe) ##1 !o_sda_oe;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("Not-acknowledge ignored");

  property p_high_first;
    @(posedge i_link_clk) disable iff (rst_l)
    (state == ibc_pkg::IBC_ACK && fall_det && rw == ibc_pkg::RW_READ && !start_det && !stop_det)
      |=> (tx_sh == $past(word_l[15:8]) && !hi_next);
  endproperty
  a_high_first: assert property (p_high_first) else $error("High byte not sent first");

  property p_never_high;
    @(posedge i_link_clk) disable iff (rst_l)
    o_sda_o == 1'b0;
  endproperty
  a_never_high: assert property (p_never_high) else $error("SDA driven high");
endmodule
`default_nettype wire

/* File: include/ibc_pkg.sv */
// Shared constants and types for the two-wire target bus-condition block
`default_nettype none
package ibc_pkg;
  // Target address default; the top-level parameter may override it
  localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h48;
  // Bit counting within one byte
  localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
  localparam logic [3:0]  BIT_CNT_RESET    = 4'h0;
  localparam logic [3:0]  BIT_CNT_STEP     = 4'h1;
  // Reset values
  localparam logic [7:0]  BYTE_RESET       = 8'h00;
  localparam logic [15:0] WORD_RESET       = 16'h0000;
  // Direction bit of the address byte: high means the master reads
  localparam logic        RW_READ          = 1'b1;
  // Open-drain pull level driven onto the data line
  localparam logic        SDA_PULL_LEVEL   = 1'b0;
  // Receive buffer entry: bit 8 marks the first byte after the address
  localparam int          RX_ENTRY_W       = 9;
  localparam int          RX_FIRST_BIT     = 8;
  localparam int          RX_DEPTH_DEFAULT = 2;

  typedef enum logic [2:0] {
    IBC_IDLE     = 3'b000,
    IBC_ADDR     = 3'b001,
    IBC_ACK      = 3'b010,
    IBC_RX       = 3'b011,
    IBC_TX       = 3'b100,
    IBC_MACK     = 3'b101,
    IBC_MACK_END = 3'b110
  } ibc_state_t;
endpackage
`default_nettype wire

/* File: sim/ibc_master_model.sv */
// Behavioural two-wire bus master driving SCL and an open-drain SDA pull
`timescale 1ns/1ps
`default_nettype none
module ibc_master_model (
  // Pacing clock and data line as seen on the wire
  input  wire logic i_clk,
  input  wire logic i_sda,
  // Bus drive
  output logic      o_scl,
  output logic      o_sda_low
);
  localparam int T_LOW  = 125;
  localparam int T_HIGH = 94;
  localparam int T_HOLD = 20;

  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Data moves only while SCL is low; sampled late in the high phase
  task automatic send_bit(input logic b, output logic r);
    o_sda_low = ~b;
    tick(T_LOW);
    o_scl = 1'b1;
    tick(T_HIGH);
    r = i_sda;
    o_scl = 1'b0;
    tick(T_HOLD);
  endtask

  // Start or repeated start
  task automatic start();
    o_sda_low = 1'b0;
    tick(T_LOW);
    o_scl = 1'b1;
    tick(T_HIGH);
    o_sda_low = 1'b1;
    tick(T_HIGH);
    o_scl = 1'b0;
    tick(T_HOLD);
  endtask

  // Stop leaves both lines released
  task automatic stop();
    o_sda_low = 1'b1;
    tick(T_LOW);
    o_scl = 1'b1;
    tick(T_HIGH);
    o_sda_low = 1'b0;
    tick(T_HIGH);
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) send_bit(b[i], r);
    send_bit(1'b1, ack);
  endtask

  // Acknowledge bit high ends the read
  task automatic read_byte(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      send_bit(1'b1, r);
      b[i] = r;
    end
    send_bit(~mack, r);
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Testbench for the two-wire target: writes, buffering, reads and aborts
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] ADDR_W = {ibc_pkg::DEV_ADDR_DEFAULT, ~ibc_pkg::RW_READ};
  localparam logic [7:0] ADDR_R = {ibc_pkg::DEV_ADDR_DEFAULT, ibc_pkg::RW_READ};
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        link_clk = 1'b0;
  logic        scl, m_low, sda, oe, sda_o, rx_valid, rx_first, tx_ready, bus_active;
  logic        rx_ready = 1'b0;
  logic        tx_valid = 1'b0;
  logic        ack, oe_q;
  logic [7:0]  rx_data, b;
  logic [15:0] tx_word = 16'h0000;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  // Wire level: pull-up unless someone pulls low
  assign sda = ~(m_low | (oe & ~sda_o));
  always #4 i_clk = ~i_clk;
  initial begin
    #37;
    forever #62.5 link_clk = ~link_clk;
  end

  ibc_slave u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_link_clk(link_clk), .i_scl(scl),
    .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(oe), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .o_rx_first(rx_first), .i_rx_ready(rx_ready),
    .i_tx_valid(tx_valid), .i_tx_word(tx_word), .o_tx_ready(tx_ready),
    .o_bus_active(bus_active));
  ibc_master_model u_mst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Wait for the head byte, compare it, then pop it
  task automatic pop_chk(input logic [7:0] d, input logic f);
    for (int k = 0; k < 200 && rx_valid !== 1'b1; k++) tick(1);
    chk("rx_valid", 16'h1, 16'(rx_valid));
    chk("rx_data", 16'(d), 16'(rx_data));
    chk("rx_first", 16'(f), 16'(rx_first));
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
    tick(1);
  endtask

  task automatic offer(input logic [15:0] w);
    tx_word = w;
    tx_valid = 1'b1;
    for (int k = 0; k < 50 && tx_ready !== 1'b1; k++) tick(1);
    tick(1);
    tx_valid = 1'b0;
    chk("tx_ready_low", 16'h0, 16'(tx_ready));
    tick(100);
    chk("tx_ready_back", 16'h1, 16'(tx_ready));
  endtask

  // Consumer stalls: two bytes buffered, one held at the link, fourth refused
  task automatic t_stall();
    u_mst.start();
    u_mst.write_byte(ADDR_W, ack);
    chk("addr_ack", 16'h0, 16'(ack));
    chk("bus_active", 16'h1, 16'(bus_active));
    u_mst.write_byte(8'ha5, ack);
    chk("ack_a", 16'h0, 16'(ack));
    u_mst.write_byte(8'h3c, ack);
    chk("ack_b", 16'h0, 16'(ack));
    u_mst.write_byte(8'h81, ack);
    chk("ack_c", 16'h0, 16'(ack));
    u_mst.write_byte(8'he7, ack);
    chk("ack_full", 16'h1, 16'(ack));
    u_mst.stop();
    tick(80);
    chk("bus_idle", 16'h0, 16'(bus_active));
    pop_chk(8'ha5, 1'b1);
    pop_chk(8'h3c, 1'b0);
    pop_chk(8'h81, 1'b0);
    tick(2);
    chk("rx_empty", 16'h0, 16'(rx_valid));
  endtask

  // Foreign address ignored, repeated start, then a flowing write
  task automatic t_flow();
    logic [7:0] d [4] = '{8'h00, 8'hff, 8'h5a, 8'h96};
    u_mst.start();
    u_mst.write_byte(ADDR_W ^ 8'h02, ack);
    chk("foreign_ack", 16'h1, 16'(ack));
    u_mst.start();
    u_mst.write_byte(ADDR_W, ack);
    chk("addr_ack", 16'h0, 16'(ack));
    for (int i = 0; i < 4; i++) begin
      u_mst.write_byte(d[i], ack);
      chk("data_ack", 16'h0, 16'(ack));
      pop_chk(d[i], i == 0);
    end
    u_mst.stop();
    tick(80);
  endtask

  // Word read, end by not-acknowledge, then high-byte-only reads
  task automatic t_read();
    offer(16'hc35a);
    u_mst.start();
    u_mst.write_byte(ADDR_R, ack);
    chk("raddr_ack", 16'h0, 16'(ack));
    u_mst.read_byte(1'b1, b);
    chk("hi_byte", 16'h00c3, 16'(b));
    u_mst.read_byte(1'b0, b);
    chk("lo_byte", 16'h005a, 16'(b));
    tick(100);
    chk("oe_after_nack", 16'h0, 16'(oe));
    repeat (2) begin
      u_mst.start();
      u_mst.write_byte(ADDR_R, ack);
      u_mst.read_byte(1'b0, b);
      chk("hi_only", 16'h00c3, 16'(b));
    end
    u_mst.stop();
    tick(80);
    chk("bus_idle", 16'h0, 16'(bus_active));
  endtask

  // Pin discipline watched on every clock, plus the hang limit
  always @(posedge i_clk) begin
    cycles++;
    if (!i_rst && scl === 1'b1 && oe !== oe_q) begin
      n_errors++;
      $display("unexpected sda_oe during scl high: expected %b seen %b", oe_q, oe);
    end
    if (!i_rst && sda_o !== 1'b0) begin
      n_errors++;
      $display("unexpected sda_o: expected 0 seen %b", sda_o);
    end
    oe_q = oe;
    if (cycles == 60000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (8) @(posedge i_clk);
    repeat (2) @(posedge link_clk);
    @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    tick(100);
    chk("idle_oe", 16'h0, 16'(oe));
    chk("idle_sda", 16'h1, 16'(sda));
    chk("idle_active", 16'h0, 16'(bus_active));
    t_stall();
    t_flow();
    t_read();
    complete_run();
  end
endmodule
`default_nettype wire
